/* File: tb/pbc_host_model.sv */
// Transmitter preburst source and receiving microcontroller model
`timescale 1ns/1ns
module pbc_host_model (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// Control from the bench
	input wire logic       txOn,
	input wire logic [7:0] halfPer,
	// Receiver side
	input wire logic       dataOut,
	input wire logic       dataOe,
	output logic           demodIn,
	output logic [7:0]     rxEdges
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       line;
		logic       lastData;
		logic [7:0] edges;
	} pbc_host_state_t;
	pbc_host_state_t q;
	pbc_host_state_t d;
	// Fixed-rate preburst toggling, and edges seen on the data pin
	always_comb begin
		d = q;
		d.cnt = q.cnt + 8'h01;
		d.lastData = dataOut;
		if (!txOn) d.cnt = 8'h00;
		else if (q.cnt == halfPer - 8'h01) begin
			d.cnt = 8'h00;
			d.line = !q.line;
		end
		if (dataOe && dataOut != q.lastData) d.edges = q.edges + 8'h01;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) q <= '0;
		else q <= d;
	end
	assign demodIn = q.line;
	assign rxEdges = q.edges;
endmodule

/* File: tb/pbc_polling_bit_check_control_bench.sv */
// Self-checking bench of the polling bit-check controller
`timescale 1ns/1ns
module pbc_polling_bit_check_control_bench;
	import pbc_pkg::*;
	logic        core_clk, rst_n, psel, penable, pwrite, clkSelPin, txOn;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  halfPer, rxEdges;
	logic        pready, pslverr, demodIn, dataOut, dataOe, sigEnable;
	int          numErrors, nTests, cycles;
	pbc_polling_ctrl #(.TICK_DIV_LO(4), .TICK_DIV_HI(5)) u_pbc_polling_ctrl (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clkSelPin(clkSelPin),
		.demodIn(demodIn), .dataOut(dataOut), .dataOe(dataOe), .sigEnable(sigEnable));
	pbc_host_model u_pbc_host_model (
		.core_clk(core_clk), .rst_n(rst_n), .txOn(txOn), .halfPer(halfPer),
		.dataOut(dataOut), .dataOe(dataOe), .demodIn(demodIn), .rxEdges(rxEdges));
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			numErrors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One APB transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		chk("apbWait", k < 50, 1'b1);
	endtask
	// Wait for sigEnable or dataOe to reach a level, counting cycles
	task automatic waitSig(input logic oe, input logic v, input int lim, output int n);
		n = 0;
		while (((oe ? dataOe : sigEnable) !== v) && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		chk("sigWait", n < lim, 1'b1);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic testDefaults;
		logic [31:0] r; logic e;
		apb(1'b1, 12'h010, 32'h0000ffff, r, e);
		chk("unmappedErr", e, 1'b1);
		apb(1'b0, ADDR_LIMIT, 32'h0, r, e);
		chk("limitReset", r, 32'h0000180e);
		apb(1'b0, ADDR_STATUS, 32'h0, r, e);
		chk("stateReset", r[1:0], 2'h0);
	endtask
	task automatic testWakeReceive;
		logic [31:0] r; logic e; int n;
		apb(1'b1, ADDR_LIMIT, 32'h0000140a, r, e);
		apb(1'b1, ADDR_OPERATING_CONFIG_REG, 32'h00000017, r, e);
		waitSig(1'b0, 1'b1, 26000, n);
		txOn <= 1'b1; halfPer <= 8'd60;
		waitSig(1'b1, 1'b1, 1500, n);
		apb(1'b0, ADDR_STATUS, 32'h0, r, e);
		chk("rxState", r[2:0], 3'h7);
		repeat (300) @(posedge core_clk);
		chk("rxFollows", rxEdges != 8'h00, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h1, r, e);
		repeat (3) @(posedge core_clk);
		chk("rxLeft", dataOe, 1'b0);
		txOn <= 1'b0;
	endtask
	task automatic testFailShort;
		logic [31:0] r; logic e; int n;
		waitSig(1'b0, 1'b1, 6000, n);
		apb(1'b1, ADDR_OPERATING_CONFIG_REG, 32'h00000417, r, e);
		txOn <= 1'b1; halfPer <= 8'd24;
		waitSig(1'b0, 1'b0, 400, n);
		chk("shortFail", n < 190, 1'b1);
		txOn <= 1'b0;
		waitSig(1'b0, 1'b1, 6000, n);
		chk("sleepLen", n >= 4090 && n <= 4140, 1'b1);
		apb(1'b0, ADDR_OPERATING_CONFIG_REG, 32'h0, r, e);
		chk("extTempClr", r[10], 1'b0);
	endtask
	task automatic testFailTimes;
		logic [31:0] r; logic e; int n;
		logic [31:0] om[4] = '{32'h017, 32'h01f, 32'h017, 32'h016};
		logic pin[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		int ex[4] = '{208, 208, 260, 416};
		for (int i = 0; i < 4; i++) begin
			// Let any active phase end so each measurement starts from sleep
			waitSig(1'b0, 1'b0, 1000, n);
			clkSelPin <= pin[i];
			apb(1'b1, ADDR_OPERATING_CONFIG_REG, om[i], r, e);
			waitSig(1'b0, 1'b1, 7000, n);
			waitSig(1'b0, 1'b0, 1000, n);
			chk("failLen", n >= ex[i] - 8 && n <= ex[i] + 24, 1'b1);
		end
		clkSelPin <= 1'b0;
	endtask
	task automatic testParkForever;
		logic [31:0] r; logic e; int n, k;
		apb(1'b1, ADDR_OPERATING_CONFIG_REG, 32'h000001f7, r, e);
		waitSig(1'b0, 1'b0, 1000, n);
		k = 0;
		repeat (6000) begin @(posedge core_clk); if (sigEnable !== 1'b0) k++; end
		chk("parked", k, 0);
		apb(1'b1, ADDR_OPERATING_CONFIG_REG, 32'h00000017, r, e);
		waitSig(1'b0, 1'b1, 4300, n);
		chk("unparked", n >= 4080, 1'b1);
		apb(1'b1, ADDR_OPERATING_CONFIG_REG, 32'h00000217, r, e);
		waitSig(1'b0, 1'b0, 1000, n);
		waitSig(1'b0, 1'b1, 33500, n);
		chk("permExt", n >= 32760 && n <= 32860, 1'b1);
	endtask
	// ------------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Cut a hung run short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 95000) begin
			numErrors++;
			report_and_stop();
		end
	end
	initial begin
		numErrors = 0; nTests = 0; cycles = 0;
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; clkSelPin = 1'b0; txOn = 1'b0; halfPer = 8'h3c;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		testDefaults();
		testWakeReceive();
		testFailShort();
		testFailTimes();
		testParkForever();
		report_and_stop();
	end
endmodule

/* File: tb/pbc_polling_monitor.sv */
// Port checker for the polling bit-check controller
`timescale 1ns/1ns
module pbc_polling_monitor #(
	parameter int TICK_DIV_LO = pbc_pkg::TICK_DIV_LO,
	parameter int TICK_DIV_HI = pbc_pkg::TICK_DIV_HI
) (
	// Clock and reset
	input wire logic                       core_clk,
	input wire logic                       rst_n,
	// APB
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [pbc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// Pins
	input wire logic                       clkSelPin,
	input wire logic                       demodIn,
	input wire logic                       dataOut,
	input wire logic                       dataOe,
	input wire logic                       sigEnable
);
	import pbc_pkg::*;
	localparam int MIN_DIV = (TICK_DIV_LO < TICK_DIV_HI) ? TICK_DIV_LO : TICK_DIV_HI;
	// The first base tick may fall in the first cycle of sleep, so only 1023 whole tick periods are assured
	localparam int MIN_SLEEP = 1023 * MIN_DIV + 2;
	typedef struct packed {logic [17:0] lowCnt;} pbc_mon_state_t;
	pbc_mon_state_t monQ;
	pbc_mon_state_t monD;
	logic           ctrlWr;
	// Saturating count of cycles with the signal path off
	always_comb begin
		monD = monQ;
		if (sigEnable) monD.lowCnt = '0;
		else if (!(&monQ.lowCnt)) monD.lowCnt = monQ.lowCnt + 18'h00001;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) monQ <= '0;
		else monQ <= monD;
	end
	// Completed write of the back-to-polling command
	assign ctrlWr = psel && penable && pready && pwrite && (paddr == ADDR_CTRL)
		&& pwdata[CMD_POLL_BIT];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence apbSetup;
		psel && !penable;
	endsequence
	sequence apbAccess;
		psel && penable && pready;
	endsequence
	chk_apb_nowait: assert property (apbSetup |=> apbAccess)
		else $error("setup not answered in next cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_err_answer: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
	chk_idle_high: assert property (!dataOe && !$past(dataOe) |-> dataOut)
		else $error("data pin low outside receive");
	chk_rx_entry: assert property ($rose(dataOe) |-> $past(sigEnable))
		else $error("receive entered without a check");
	chk_rx_exit: assert property ($fell(dataOe) |-> $past(ctrlWr) || $past(ctrlWr, 2))
		else $error("receive left without command");
	chk_rx_sync: assert property (dataOe && $changed(dataOut) |=> (!dataOe || $stable(dataOut)) [*3])
		else $error("data changed between ticks");
	chk_sleep_span: assert property ($rose(sigEnable) |-> monQ.lowCnt >= MIN_SLEEP)
		else $error("sleep shorter than one unit");
endmodule
bind pbc_polling_ctrl pbc_polling_monitor #(
	.TICK_DIV_LO(TICK_DIV_LO),
	.TICK_DIV_HI(TICK_DIV_HI)
) u_pbc_polling_monitor (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .clkSelPin(clkSelPin), .demodIn(demodIn),
	.dataOut(dataOut), .dataOe(dataOe), .sigEnable(sigEnable)
);

/* File: verilog/pbc_pkg.sv */
// Constants, field layout and types shared by the polling bit-check controller
package pbc_pkg;

	// ------------------------------------------------------------------
	// Clock and base tick timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 8000;     // Core clock period, 125 MHz
	localparam int TICK_LO_PS     = 2038300;  // Base tick with clock-select low
	localparam int TICK_HI_PS     = 2069700;  // Base tick with clock-select high
	localparam int TICK_DIV_LO    = TICK_LO_PS / CLK_PERIOD_PS;
	localparam int TICK_DIV_HI    = TICK_HI_PS / CLK_PERIOD_PS;
	localparam int DIV_W          = 9;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam int                ADDR_W      = 12;
	localparam logic [ADDR_W-1:0] ADDR_OPERATING_CONFIG_REG = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT  = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BAUD_LSB     = 0;   // 2 bits, baud_range_sel
	localparam int NBIT_LSB     = 2;   // 2 bits, checked-bit count code
	localparam int SLEEP_LSB    = 4;   // 5 bits, sleep value
	localparam int EXTP_BIT     = 9;   // sleep_ext_permanent
	localparam int EXTT_BIT     = 10;  // sleep_ext_temporary
	localparam int LMIN_LSB     = 0;   // Lower window bound
	localparam int LMAX_LSB     = 8;   // Upper window bound
	localparam int CMD_POLL_BIT = 0;   // Write 1: back to polling
	localparam int ST_LSB       = 0;   // Status: state code
	localparam int RXM_BIT      = 2;   // Status: receiving mode
	localparam int CHK_LSB      = 8;   // Status: passed checks
	localparam int IVC_LSB      = 16;  // Status: edge_interval_count

	// ------------------------------------------------------------------
	// Field widths, reset values and timing factors
	// ------------------------------------------------------------------
	localparam int           SLEEP_W      = 5;
	localparam int           LIM_W        = 6;
	localparam int           CHK_W        = 5;
	localparam int           TMR_W        = 18;
	localparam logic [1:0]   BAUD_RST     = 2'h1;
	localparam logic [1:0]   NBIT_RST     = 2'h1;
	localparam logic [4:0]   SLEEP_RST    = 5'h05;
	localparam logic [4:0]   SLEEP_MAX    = 5'h1f;
	localparam logic [5:0]   LIM_MIN_RST  = 6'h0e;  // 14
	localparam logic [5:0]   LIM_MAX_RST  = 6'h18;  // 24
	localparam logic [17:0]  SLEEP_UNIT   = 18'h00400;  // 1024 base ticks
	localparam logic [3:0]   SLEEP_EXT    = 4'h8;
	localparam logic [3:0]   XTICK_RANGE0 = 4'h8;
	localparam logic [4:0]   CHK_PER_STEP = 5'h06;  // 3 bits, 2 checks each
	localparam logic [17:0]  WARMUP_XT    = 18'h00020;  // Warm-up in extended ticks

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_WARMUP,
		ST_CHECK,
		ST_RECEIVE
	} pbc_state_t;

endpackage

/* File: verilog/pbc_polling_ctrl.sv */
// Polling, bit-check and receive-mode controller with APB register access
// ------------------------------------------------------------------
// Summary of operation
// - Base tick from divider whose factor follows the clock-select pin.
// - Extended tick is 8, 4, 2 or 1 base ticks by baud range.
// - Polling loops through sleep, warm-up and bit-check phases.
// - Warm-up enables signal path; demodulator output is ignored meanwhile.
// - Warm-up length depends on baud range and base tick.
// - Sleep lasts sleep value times extension factor times 1024 base ticks.
// - Permanent extension bit forces extension factor eight.
// - Temporary extension holds while checks pass; first failure clears it.
// - Highest sleep value sleeps until another value is written.
// - Checked bits 0, 3, 6 or 9, two interval checks per bit.
// - Intervals inside window continue; outside window returns to sleep.
// - Window bounds held in limit register, scaled by extended tick.
// - Interval counter advances on extended tick during bit check.
// - Fail if count below lower bound at edge, or reaching upper bound.
// - Reset bounds are 14 lower and 24 upper.
// - After all checks pass, demodulated data drives the data pin.
// - Failing check duration does not depend on checked-bit count.
// - Success enters receiving mode until commanded back to polling.
// - In receiving mode data output changes only on extended tick.
// ------------------------------------------------------------------
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module pbc_polling_ctrl #(
	parameter int TICK_DIV_LO = pbc_pkg::TICK_DIV_LO,
	parameter int TICK_DIV_HI = pbc_pkg::TICK_DIV_HI
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pbc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Pins
	input  wire logic                       clkSelPin,
	input  wire logic                       demodIn,
	output logic                            dataOut,
	output logic                            dataOe,
	output logic                            sigEnable
);
	import pbc_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0]         selSync;
		logic [1:0]         demSync;
		logic [DIV_W-1:0]   baseCnt;
		logic [3:0]         xCnt;
		pbc_state_t         state;
		logic [TMR_W-1:0]   timer;
		logic [LIM_W-1:0]   ivCnt;
		logic [CHK_W-1:0]   checks;
		logic               demPrev;
		logic [1:0]         baud;
		logic [1:0]         nbit;
		logic [SLEEP_W-1:0] sleepVal;
		logic               extPerm;
		logic               extTemp;
		logic [LIM_W-1:0]   limMin;
		logic [LIM_W-1:0]   limMax;
		logic [31:0]        rdata;
		logic               ready;
		logic               slverr;
		logic               data;
		logic               oe;
		logic               sigEn;
	} pbc_regs_t;

	pbc_regs_t r_q;
	pbc_regs_t r_d;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Extended tick length in base ticks for a baud range
	function automatic logic [3:0] xtickLen(input logic [1:0] range);
		xtickLen = XTICK_RANGE0 >> range;
	endfunction

	// Number of interval checks for a checked-bit code
	function automatic logic [CHK_W-1:0] checkTarget(input logic [1:0] code);
		logic [CHK_W-1:0] acc;
		// Three steps of six checks give 0, 6, 12 or 18
		acc = '0;
		for (int i = 0; i < 3; i++) begin
			if (i < int'(code)) begin
				acc = acc + CHK_PER_STEP;
			end
		end
		checkTarget = acc;
	endfunction

	// Sleep length in base ticks
	function automatic logic [TMR_W-1:0] sleepLen(input logic [SLEEP_W-1:0] val,
	                                              input logic               ext);
		logic [TMR_W-1:0] base;
		// The longest sleep, 31 units extended eightfold, still fits the timer
		base = TMR_W'(val) * SLEEP_UNIT;
		sleepLen = ext ? (base * TMR_W'(SLEEP_EXT)) : base;
	endfunction

	// Register read decode
	function automatic logic [31:0] readMux(input pbc_regs_t s,
	                                        input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			ADDR_OPERATING_CONFIG_REG: begin
				v[BAUD_LSB +: 2]        = s.baud;
				v[NBIT_LSB +: 2]        = s.nbit;
				v[SLEEP_LSB +: SLEEP_W] = s.sleepVal;
				v[EXTP_BIT]             = s.extPerm;
				v[EXTT_BIT]             = s.extTemp;
			end
			ADDR_LIMIT: begin
				v[LMIN_LSB +: LIM_W] = s.limMin;
				v[LMAX_LSB +: LIM_W] = s.limMax;
			end
			ADDR_STATUS: begin
				v[ST_LSB +: 2]       = s.state;
				v[RXM_BIT]           = (s.state == ST_RECEIVE);
				v[CHK_LSB +: CHK_W]  = s.checks;
				v[IVC_LSB +: LIM_W]  = s.ivCnt;
			end
			default: begin
				v = '0;
			end
		endcase
		readMux = v;
	endfunction

	// Address is one of the mapped words
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		isMapped = (a == ADDR_OPERATING_CONFIG_REG) || (a == ADDR_LIMIT) ||
		           (a == ADDR_CTRL) || (a == ADDR_STATUS);
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	logic               baseTick;
	logic               xTick;
	logic [DIV_W-1:0]   divLen;
	logic               wrEn;
	logic               pollCmd;
	logic               demNow;
	logic               edgeSeen;
	logic               extOn;

	always_comb begin
		r_d = r_q;

		// Pin synchronisers
		// Only the second flop of each pair is read; the first may be metastable
		r_d.selSync = {r_q.selSync[0], clkSelPin};
		r_d.demSync = {r_q.demSync[0], demodIn};
		demNow      = r_q.demSync[1];

		// Base tick divider, factor chosen by clock-select pin
		// A factor shortened mid-count only fires one tick early
		divLen   = r_q.selSync[1] ? DIV_W'(TICK_DIV_HI) : DIV_W'(TICK_DIV_LO);
		baseTick = (r_q.baseCnt >= divLen - DIV_W'(1));
		r_d.baseCnt = baseTick ? '0 : r_q.baseCnt + DIV_W'(1);

		// Extended tick from base ticks
		xTick = baseTick && (r_q.xCnt >= xtickLen(r_q.baud) - 4'h1);
		if (baseTick) begin
			r_d.xCnt = xTick ? 4'h0 : r_q.xCnt + 4'h1;
		end

		// APB access phase handling
		// Zero wait states: the answer is prepared in the setup cycle,
		// so pready stands for exactly the first access cycle
		wrEn    = psel && penable && r_q.ready && pwrite;
		pollCmd = 1'b0;
		if (psel && !penable) begin
			r_d.ready  = 1'b1;
			r_d.slverr = !isMapped(paddr);
			r_d.rdata  = pwrite ? 32'h0 : readMux(r_q, paddr);
		end else if (psel && penable && r_q.ready) begin
			r_d.ready  = 1'b0;
			r_d.slverr = 1'b0;
		end

		// Register writes
		// A write lands on the access edge that samples pready high
		if (wrEn) begin
			case (paddr)
				ADDR_OPERATING_CONFIG_REG: begin
					r_d.baud     = pwdata[BAUD_LSB +: 2];
					r_d.nbit     = pwdata[NBIT_LSB +: 2];
					r_d.sleepVal = pwdata[SLEEP_LSB +: SLEEP_W];
					r_d.extPerm  = pwdata[EXTP_BIT];
					r_d.extTemp  = pwdata[EXTT_BIT];
				end
				ADDR_LIMIT: begin
					r_d.limMin = pwdata[LMIN_LSB +: LIM_W];
					r_d.limMax = pwdata[LMAX_LSB +: LIM_W];
				end
				ADDR_CTRL: begin
					pollCmd = pwdata[CMD_POLL_BIT];
				end
				default: begin
					pollCmd = 1'b0;
				end
			endcase
		end

		// Sleep extension uses register values as they stand now
		// A failure clearing the temporary bit shortens the very next sleep
		extOn    = r_q.extPerm || r_q.extTemp;
		edgeSeen = (demNow != r_q.demPrev);

		// Phase sequencer
		// The timer counts base ticks in sleep and extended ticks in warm-up
		case (r_q.state)
			ST_SLEEP: begin
				r_d.sigEn = 1'b0;
				r_d.oe    = 1'b0;
				if (r_q.sleepVal == SLEEP_MAX) begin
					// Parked: hold the timer so a new value restarts a full sleep
					r_d.timer = '0;
				end else if (r_q.timer >= sleepLen(r_q.sleepVal, extOn)) begin
					r_d.state = ST_WARMUP;
					r_d.timer = '0;
					r_d.sigEn = 1'b1;
				end else if (baseTick) begin
					r_d.timer = r_q.timer + TMR_W'(1);
				end
			end
			ST_WARMUP: begin
				// Demodulator output is not looked at while settling
				r_d.sigEn = 1'b1;
				if (r_q.timer >= WARMUP_XT) begin
					r_d.timer   = '0;
					r_d.ivCnt   = '0;
					r_d.checks  = '0;
					r_d.demPrev = demNow;
					if (checkTarget(r_q.nbit) == '0) begin
						r_d.state = ST_RECEIVE;
						r_d.data  = demNow;
						r_d.oe    = 1'b1;
					end else begin
						r_d.state = ST_CHECK;
					end
				end else if (xTick) begin
					r_d.timer = r_q.timer + TMR_W'(1);
				end
			end
			ST_CHECK: begin
				r_d.demPrev = demNow;
				if (edgeSeen) begin
					// An edge that lands as the count reaches the upper bound is too late
					if ((r_q.ivCnt < r_q.limMin) || (r_q.ivCnt >= r_q.limMax)) begin
						r_d.state   = ST_SLEEP;
						r_d.extTemp = 1'b0;
						r_d.sigEn   = 1'b0;
					end else if (r_q.checks + CHK_W'(1) >= checkTarget(r_q.nbit)) begin
						// The last passing edge hands the pin over at once
						r_d.state  = ST_RECEIVE;
						r_d.checks = r_q.checks + CHK_W'(1);
						r_d.data   = demNow;
						r_d.oe     = 1'b1;
					end else begin
						r_d.checks = r_q.checks + CHK_W'(1);
						r_d.ivCnt  = '0;
					end
				end else if (r_q.ivCnt >= r_q.limMax) begin
					r_d.state   = ST_SLEEP;
					r_d.extTemp = 1'b0;
					r_d.sigEn   = 1'b0;
				end else if (xTick) begin
					// The upper-bound failure stops the count at the bound, at most 63, so it never wraps
					r_d.ivCnt = r_q.ivCnt + LIM_W'(1);
				end
			end
			ST_RECEIVE: begin
				r_d.oe = 1'b1;
				if (xTick) begin
					r_d.data = demNow;
				end
				if (pollCmd) begin
					r_d.state = ST_SLEEP;
					r_d.timer = '0;
					r_d.oe    = 1'b0;
					r_d.sigEn = 1'b0;
					// Leave the pin high, its resting level
					r_d.data  = 1'b1;
				end
			end
			default: begin
				r_d.state = ST_SLEEP;
			end
		endcase

		// Software write of the temporary bit wins over the hardware clear
		if (wrEn && (paddr == ADDR_OPERATING_CONFIG_REG)) begin
			r_d.extTemp = pwdata[EXTT_BIT];
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Reset loads the default configuration and window bounds
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q          <= '0;
			r_q.state    <= ST_SLEEP;
			r_q.baud     <= BAUD_RST;
			r_q.nbit     <= NBIT_RST;
			r_q.sleepVal <= SLEEP_RST;
			r_q.limMin   <= LIM_MIN_RST;
			r_q.limMax   <= LIM_MAX_RST;
			r_q.data     <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------------
	// Data rests high so a sleeping receiver never shows a false start edge
	assign prdata    = r_q.rdata;
	assign pready    = r_q.ready;
	assign pslverr   = r_q.slverr;
	assign dataOut   = r_q.data;
	assign dataOe    = r_q.oe;
	assign sigEnable = r_q.sigEn;

endmodule
